// ### hdl/mmc_pkg.sv
// Package: register map, field positions, reset values and carrier types of the memory config block
package mmc_pkg;

   // ==========================================================
   // Register offsets (byte offsets from node / broadcast base)
   // ==========================================================
   localparam logic [19:0] OFF_INTERLEAVE_CONTROL   = 20'h01840;
   localparam logic [19:0] OFF_ARRAY_CONFIGURATION  = 20'h01880;
   localparam logic [19:0] OFF_SEGMENT_FAILURES     = 20'h018C0;

   // ==========================================================
   // interleave_control fields
   // ==========================================================
   localparam int          MIC_ENABLE_BIT           = 31;
   localparam int          MIC_FACTOR_LSB           = 0;
   localparam int          MIC_FACTOR_W             = 3;
   localparam logic [2:0]  MIC_FACTOR_MAX           = 3'h4;
   localparam logic [31:0] MIC_RESET                = 32'h00000000;

   // ==========================================================
   // array_configuration fields
   // ==========================================================
   localparam int          CFG_BATTERY_OK_BIT       = 31;
   localparam int          CFG_BATTERY_DISCONNECT   = 30;
   localparam int          CFG_BATTERY_RECONNECT    = 29;
   localparam int          CFG_BATTERY_IS_DISC      = 28;
   localparam int          CFG_OPTION_BIT           = 9;
   localparam int          CFG_SHARED_BIT           = 8;
   localparam int          CFG_DEFAULT_BIT          = 6;
   localparam int          CFG_RATE_LSB             = 4;
   localparam int          CFG_STRINGS_LSB          = 2;
   localparam int          CFG_DRAM_TYPE_BIT        = 0;
   localparam logic [1:0]  RATE_RESET               = 2'h0;

   // Refresh counter values per timing-rate code
   localparam logic [10:0] REFRESH_RATE_00          = 11'h550; // 1360
   localparam logic [10:0] REFRESH_RATE_10          = 11'h440; // 1088
   localparam logic [10:0] REFRESH_RATE_11          = 11'h3F0; // 1008
   localparam logic [10:0] REFRESH_RESERVED         = 11'h000;

   // ==========================================================
   // Segment failure register
   // ==========================================================
   localparam int          SEG_COUNT                = 32;
   localparam int          SEG_ADDR_SHIFT           = 26;   // 64 Mbytes per segment
   localparam logic [31:0] SEG_RESET                = 32'h00000000;

   // ==========================================================
   // Carrier types
   // ==========================================================
   typedef struct packed {
      logic        valid;     // Access strobe, one cycle
      logic        write;     // 1 write, 0 read
      logic        broadcast; // Address decoded in broadcast space
      logic [19:0] offset;
      logic [31:0] wdata;
   } mmc_csr_req_t;

   typedef struct packed {
      logic        valid;     // One cycle after request
      logic        hit;       // Offset mapped
      logic [31:0] rdata;
   } mmc_csr_rsp_t;

   typedef struct packed {
      logic        valid;     // One-cycle mismatch report
      logic [30:0] addr;      // Byte address within module (2 Gbyte span)
   } mmc_mismatch_t;

endpackage : mmc_pkg

// ### hdl/mmc_battery_ctl.sv
// Battery disconnect sequencer for the nonvolatile SRAM option
`timescale 1ns/1ps

module mmc_battery_ctl (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_cfg_write,   // One-cycle write to array_configuration
   input  wire logic i_disc_bit,    // Written value of the disconnect bit
   input  wire logic i_reconn_bit,  // Written value of the reconnect bit
   output logic      o_disconnected,
   output logic      o_battery_ctl
);

   typedef enum logic [1:0] {MMC_BAT_ON, MMC_BAT_ARMED, MMC_BAT_OFF} mmc_bat_state_t;

   typedef struct packed {
      mmc_bat_state_t st;
      logic           ctl;
   } mmc_bat_t;

   mmc_bat_t bat_reg;
   mmc_bat_t bat_next;

   // ==========================================================
   // Next state: two successive writes with disconnect set
   // ==========================================================
   always_comb begin
      bat_next = bat_reg;
      if (i_cfg_write) begin
         if (i_reconn_bit) begin
            bat_next.st = MMC_BAT_ON;
         end else begin
            unique case (bat_reg.st)
               MMC_BAT_ON:    bat_next.st = i_disc_bit ? MMC_BAT_ARMED : MMC_BAT_ON;
               // A clear write in between cancels the pending disconnect
               MMC_BAT_ARMED: bat_next.st = i_disc_bit ? MMC_BAT_OFF : MMC_BAT_ON;
               MMC_BAT_OFF:   bat_next.st = MMC_BAT_OFF;
            endcase
         end
      end
      bat_next.ctl = (bat_next.st != MMC_BAT_OFF);
   end

   // Reset forces the battery connected and the control pin high
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         bat_reg.st  <= MMC_BAT_ON;
         bat_reg.ctl <= 1'b1;
      end else begin
         bat_reg <= bat_next;
      end
   end

   assign o_disconnected = (bat_reg.st == MMC_BAT_OFF);
   assign o_battery_ctl  = bat_reg.ctl;

endmodule // mmc_battery_ctl

// ### hdl/mmc_config_regs.sv
// Memory module configuration and status register bank
//
// Contract
// - Memory-space response only while enable bit set
// - Decode interleave field; codes 5-7 reserved
// - Configuration writes accepted at broadcast address too
// - Bit 31 reports battery health, read-only
// - Two successive disconnect writes disconnect battery
// - Battery pin low when disconnected, high at reset
// - Reconnect bit restores a disconnected battery
// - Disconnected status set, cleared by reset/reconnect
// - Bit 9 array type; SRAM inhibits refresh, self-test
// - SRAM plus shared bit asserts bus shared line
// - Default bit set at reset, cleared by rate write
// - Timing-rate code selects refresh counter value
// - Bits 3:2 report installed string count
// - Mismatch sets segment bit; write one clears
// - Segment n spans 64 Mbytes starting at n times 64 Mbytes
// - Continue strobe in pause mode clears segments
// - Self-test addresses as sole module, no interleave
// - Continue strobe honoured only in pause mode
`timescale 1ns/1ps

module mmc_config_regs (
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst_n,
   // CSR access from the system bus interface
   input  wire mmc_pkg::mmc_csr_req_t i_csr_req,
   output mmc_pkg::mmc_csr_rsp_t      o_csr_rsp,
   // Memory-space transaction targeting this module
   input  wire logic                  i_mem_access,
   // Straps and sensors (asynchronous, synchronised here)
   input  wire logic                  i_battery_ok,
   input  wire logic                  i_option_dram,
   input  wire logic [1:0]            i_string_count,
   input  wire logic                  i_dram_type,
   // Self-test engine
   input  wire logic                  i_selftest_active,
   input  wire logic                  i_pause_on_error_mode,
   input  wire logic                  i_pause_on_error_continue,
   input  wire mmc_pkg::mmc_mismatch_t i_mismatch,
   // Memory control outputs
   output logic                       o_mem_respond,
   output logic [2:0]                 o_interleave_factor,
   output logic                       o_interleave_reserved,
   output logic                       o_selftest_sole_module,
   output logic [10:0]                o_refresh_count,
   output logic                       o_refresh_enable,
   output logic                       o_selftest_enable,
   output logic                       o_bus_shared_line,
   output logic                       o_battery_ctl
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic        enable;
      logic [2:0]  factor;
      logic        shared;
      logic        dflt;
      logic [1:0]  rate;
      logic [31:0] seg_fail;
      logic [1:0]  bat_ok_s;
      logic [1:0]  opt_s;
      logic [3:0]  str_s;
      logic [1:0]  dtype_s;
      mmc_pkg::mmc_csr_rsp_t rsp;
      logic        respond;
      logic        ilv_rsvd;
      logic        shared_out;
      logic [10:0] refresh;
   } mmc_state_t;

   mmc_state_t st_reg;
   mmc_state_t st_next;

   logic       bat_disc;
   logic       bat_ctl;
   logic       cfg_wr;
   logic       hit_ilv;
   logic       hit_cfg;
   logic       hit_seg;
   logic       node_rd;
   logic       node_wr;
   logic       sram;
   logic [4:0] seg_idx;
   logic [31:0] seg_set;
   logic [31:0] seg_clr;

   // ==========================================================
   // Address decode
   // ==========================================================
   // Broadcast space holds only the configuration register, and is write-only
   assign node_rd = i_csr_req.valid & ~i_csr_req.write & ~i_csr_req.broadcast;
   assign node_wr = i_csr_req.valid &  i_csr_req.write & ~i_csr_req.broadcast;
   assign hit_ilv = (i_csr_req.offset == mmc_pkg::OFF_INTERLEAVE_CONTROL);
   assign hit_cfg = (i_csr_req.offset == mmc_pkg::OFF_ARRAY_CONFIGURATION);
   assign hit_seg = (i_csr_req.offset == mmc_pkg::OFF_SEGMENT_FAILURES);
   assign cfg_wr  = i_csr_req.valid & i_csr_req.write & hit_cfg;
   assign sram    = ~st_reg.opt_s[1];

   // Segment index from the address, fixed to the 2 Gbyte maximum map
   assign seg_idx = i_mismatch.addr[30:mmc_pkg::SEG_ADDR_SHIFT];

   // ==========================================================
   // Per-segment set and clear terms
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < mmc_pkg::SEG_COUNT; g++) begin : g_seg
         // Mismatches only count while self-test is allowed to run
         assign seg_set[g] = i_mismatch.valid & ~sram & (seg_idx == 5'(g));
         assign seg_clr[g] = node_wr & hit_seg & i_csr_req.wdata[g];
      end
   endgenerate

   // ==========================================================
   // Battery sequencer
   // ==========================================================
   mmc_battery_ctl u_battery (
      .i_mclk         (i_mclk),
      .i_rst_n        (i_rst_n),
      .i_cfg_write    (cfg_wr),
      .i_disc_bit     (i_csr_req.wdata[mmc_pkg::CFG_BATTERY_DISCONNECT]),
      .i_reconn_bit   (i_csr_req.wdata[mmc_pkg::CFG_BATTERY_RECONNECT]),
      .o_disconnected (bat_disc),
      .o_battery_ctl  (bat_ctl)
   );

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_next = st_reg;

      // Two-flop synchronisers on straps and battery sensor
      st_next.bat_ok_s = {st_reg.bat_ok_s[0], i_battery_ok};
      st_next.opt_s    = {st_reg.opt_s[0], i_option_dram};
      st_next.str_s    = {st_reg.str_s[1:0], i_string_count};
      st_next.dtype_s  = {st_reg.dtype_s[0], i_dram_type};

      // Interleave register writes; reserved bits dropped
      if (node_wr && hit_ilv) begin
         st_next.enable = i_csr_req.wdata[mmc_pkg::MIC_ENABLE_BIT];
         st_next.factor = i_csr_req.wdata[mmc_pkg::MIC_FACTOR_LSB +: mmc_pkg::MIC_FACTOR_W];
      end

      // Configuration writes, from node or broadcast space
      if (cfg_wr) begin
         st_next.shared = i_csr_req.wdata[mmc_pkg::CFG_SHARED_BIT];
         st_next.rate   = i_csr_req.wdata[mmc_pkg::CFG_RATE_LSB +: 2];
         st_next.dflt   = 1'b0;
      end

      // Set wins over a same-cycle write-one or continue clear; continue clears all other bits
      if (i_pause_on_error_continue && i_pause_on_error_mode && i_selftest_active) begin
         st_next.seg_fail = seg_set;
      end else begin
         st_next.seg_fail = (st_reg.seg_fail & ~seg_clr) | seg_set;
      end

      // Read mux; unmapped offsets answer zero with hit low
      st_next.rsp = '0;
      if (i_csr_req.valid) begin
         st_next.rsp.valid = 1'b1;
         st_next.rsp.hit   = hit_ilv | hit_cfg | hit_seg;
      end
      if (node_rd) begin
         if (hit_ilv) begin
            st_next.rsp.rdata[mmc_pkg::MIC_ENABLE_BIT] = st_reg.enable;
            st_next.rsp.rdata[2:0] = st_reg.factor;
         end
         if (hit_cfg) begin
            st_next.rsp.rdata[mmc_pkg::CFG_BATTERY_OK_BIT]  = st_reg.bat_ok_s[1];
            st_next.rsp.rdata[mmc_pkg::CFG_BATTERY_IS_DISC] = bat_disc;
            st_next.rsp.rdata[mmc_pkg::CFG_OPTION_BIT]      = st_reg.opt_s[1];
            st_next.rsp.rdata[mmc_pkg::CFG_SHARED_BIT]      = st_reg.shared;
            st_next.rsp.rdata[mmc_pkg::CFG_DEFAULT_BIT]     = st_reg.dflt;
            st_next.rsp.rdata[mmc_pkg::CFG_RATE_LSB +: 2]   = st_reg.rate;
            st_next.rsp.rdata[mmc_pkg::CFG_STRINGS_LSB +: 2] = st_reg.str_s[3:2];
            st_next.rsp.rdata[mmc_pkg::CFG_DRAM_TYPE_BIT]   = st_reg.dtype_s[1];
         end
         if (hit_seg) begin
            st_next.rsp.rdata = st_reg.seg_fail;
         end
      end

      // Memory-space gating and interleave decode
      st_next.respond  = st_next.enable;
      st_next.ilv_rsvd = (st_next.factor > mmc_pkg::MIC_FACTOR_MAX);
      st_next.shared_out = i_mem_access & st_reg.enable & st_reg.shared & sram;

      // Refresh counter value from the timing-rate code
      unique case (st_next.rate)
         2'h0:    st_next.refresh = mmc_pkg::REFRESH_RATE_00;
         2'h2:    st_next.refresh = mmc_pkg::REFRESH_RATE_10;
         2'h3:    st_next.refresh = mmc_pkg::REFRESH_RATE_11;
         default: st_next.refresh = mmc_pkg::REFRESH_RESERVED;
      endcase
   end

   // ==========================================================
   // Register update
   // ==========================================================
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st_reg          <= '0;
         st_reg.dflt     <= 1'b1;
         st_reg.rate     <= mmc_pkg::RATE_RESET;
         st_reg.seg_fail <= mmc_pkg::SEG_RESET;
         st_reg.refresh  <= mmc_pkg::REFRESH_RATE_00;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs, all from flip-flops except the constant sole-module flag
   // ==========================================================
   assign o_csr_rsp              = st_reg.rsp;
   assign o_mem_respond          = st_reg.respond;
   assign o_interleave_factor    = st_reg.factor;
   assign o_interleave_reserved  = st_reg.ilv_rsvd;
   assign o_selftest_sole_module = 1'b1;    // Self-test never interleaves
   assign o_refresh_count        = st_reg.refresh;
   // SRAM arrays must not be refreshed or tested
   assign o_refresh_enable       = st_reg.opt_s[1];
   assign o_selftest_enable      = st_reg.opt_s[1];
   assign o_bus_shared_line      = st_reg.shared_out;
   assign o_battery_ctl          = bat_ctl;

endmodule // mmc_config_regs

// ### testbench/mmc_cmdr_model.sv
// Bus commander model issuing CSR reads and writes to the register bank
`timescale 1ns/1ps
module mmc_cmdr_model (
   input  wire logic                  i_mclk,
   output mmc_pkg::mmc_csr_req_t      o_req,
   input  wire mmc_pkg::mmc_csr_rsp_t i_rsp
);
   initial o_req = '0;
   // One word per call; request held until the taking edge, released data inverted
   task automatic access(input logic wr, input logic bc, input logic [19:0] off,
                         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge i_mclk);
      #1;
      o_req = '{valid: 1'b1, write: wr, broadcast: bc, offset: off, wdata: wd};
      @(posedge i_mclk);
      #1;
      o_req.valid = 1'b0;
      o_req.wdata = ~wd;
      rd = i_rsp.rdata;
   endtask
endmodule // mmc_cmdr_model

// ### testbench/mmc_config_regs_asserts.sv
// Concurrent checks on the ports of the memory configuration register bank
`timescale 1ns/1ps
module mmc_config_regs_asserts (
   input wire logic                  i_mclk,
   input wire logic                  i_rst_n,
   input wire mmc_pkg::mmc_csr_req_t i_csr_req,
   input wire mmc_pkg::mmc_csr_rsp_t o_csr_rsp,
   input wire logic                  i_mem_access,
   input wire logic                  o_mem_respond,
   input wire logic [2:0]            o_interleave_factor,
   input wire logic                  o_interleave_reserved,
   input wire logic                  o_selftest_sole_module,
   input wire logic [10:0]           o_refresh_count,
   input wire logic                  o_refresh_enable,
   input wire logic                  o_selftest_enable,
   input wire logic                  o_bus_shared_line,
   input wire logic                  o_battery_ctl
);
   // ==========================================================
   // Decoded writes
   // ==========================================================
   // Interleave writes count only at the node address, not in broadcast space
   wire logic mic_wr = i_csr_req.valid && i_csr_req.write && !i_csr_req.broadcast &&
                       i_csr_req.offset == mmc_pkg::OFF_INTERLEAVE_CONTROL;
   wire logic cfg_wr = i_csr_req.valid && i_csr_req.write &&
                       i_csr_req.offset == mmc_pkg::OFF_ARRAY_CONFIGURATION;
   wire logic disc_wr = cfg_wr && i_csr_req.wdata[30] && !i_csr_req.wdata[29];
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   function automatic logic [10:0] rate_count(input logic [1:0] code);
      case (code)
         2'h0: rate_count = 11'h550;
         2'h2: rate_count = 11'h440;
         2'h3: rate_count = 11'h3F0;
         default: rate_count = 11'h000;
      endcase
   endfunction
   // ==========================================================
   // Properties
   // ==========================================================
   sequence s_reconn_wr; cfg_wr && i_csr_req.wdata[29]; endsequence
   sequence s_unmapped_rd;
      i_csr_req.valid && !i_csr_req.write && i_csr_req.offset == 20'h01844;
   endsequence
   property p_unmapped; s_unmapped_rd |=> o_csr_rsp.valid && !o_csr_rsp.hit &&
      o_csr_rsp.rdata == 32'h0; endproperty
   property p_respond; mic_wr |=> o_mem_respond == $past(i_csr_req.wdata[31]); endproperty
   property p_respond_hold; !mic_wr |=> $stable(o_mem_respond); endproperty
   property p_factor; mic_wr |=> o_interleave_factor == $past(i_csr_req.wdata[2:0]) &&
      o_interleave_reserved == (o_interleave_factor > 3'h4); endproperty
   property p_sole; o_selftest_sole_module; endproperty
   property p_rate; cfg_wr |=> o_refresh_count == rate_count($past(i_csr_req.wdata[5:4]));
   endproperty
   property p_disc; $fell(o_battery_ctl) |-> $past(disc_wr); endproperty
   property p_reconn; s_reconn_wr |=> o_battery_ctl [*2]; endproperty
   property p_shared; o_bus_shared_line |->
      $past(i_mem_access && o_mem_respond && !o_refresh_enable); endproperty
   property p_enables; o_refresh_enable == o_selftest_enable; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
   a_respond: assert property (p_respond) else $error("enable bit not applied");
   a_respond_hold: assert property (p_respond_hold) else $error("enable moved");
   a_factor: assert property (p_factor) else $error("interleave decode wrong");
   a_sole: assert property (p_sole) else $error("self-test not sole module");
   a_rate: assert property (p_rate) else $error("refresh count wrong");
   a_disc: assert property (p_disc) else $error("battery dropped without write");
   a_reconn: assert property (p_reconn) else $error("battery not reconnected");
   a_shared: assert property (p_shared) else $error("shared line unexpected");
   a_enables: assert property (p_enables) else $error("enables differ");
endmodule // mmc_config_regs_asserts

bind mmc_config_regs mmc_config_regs_asserts i_chk (.i_mclk, .i_rst_n, .i_csr_req,
   .o_csr_rsp, .i_mem_access, .o_mem_respond, .o_interleave_factor, .o_interleave_reserved,
   .o_selftest_sole_module, .o_refresh_count, .o_refresh_enable, .o_selftest_enable,
   .o_bus_shared_line, .o_battery_ctl);

// ### testbench/tb_top.sv
// Self-checking testbench for the memory configuration register bank
`timescale 1ns/1ps
module tb_top;
   logic                   i_mclk, i_rst_n, i_mem_access, i_battery_ok, i_option_dram;
   logic                   i_selftest_active, i_pause_on_error_mode, i_pause_on_error_continue;
   logic                   o_mem_respond, o_interleave_reserved, o_refresh_enable;
   logic                   o_bus_shared_line, o_battery_ctl;
   logic [2:0]             o_interleave_factor;
   logic [10:0]            o_refresh_count;
   logic [31:0]            rd, seg;
   logic [1:0]             rate, string_count;
   mmc_pkg::mmc_csr_req_t  i_csr_req;
   mmc_pkg::mmc_csr_rsp_t  o_csr_rsp;
   mmc_pkg::mmc_mismatch_t i_mismatch;
   int                     fail_count = 0;
   int                     cmp_count = 0;
   int                     cycles = 0;
   localparam logic [10:0] EXP_CNT [4] = '{11'h550, 11'h000, 11'h440, 11'h3F0};
   localparam logic [19:0] MIC = mmc_pkg::OFF_INTERLEAVE_CONTROL;
   localparam logic [19:0] CFG = mmc_pkg::OFF_ARRAY_CONFIGURATION;
   localparam logic [19:0] SEG = mmc_pkg::OFF_SEGMENT_FAILURES;

   // Technology type strap stays fixed and both self-test outputs are left open; every other port is exercised
   mmc_config_regs i_dut (.i_mclk, .i_rst_n, .i_csr_req, .o_csr_rsp, .i_mem_access,
      .i_battery_ok, .i_option_dram, .i_string_count(string_count), .i_dram_type(1'b1),
      .i_selftest_active, .i_pause_on_error_mode, .i_pause_on_error_continue, .i_mismatch,
      .o_mem_respond, .o_interleave_factor, .o_interleave_reserved,
      .o_selftest_sole_module(), .o_refresh_count, .o_refresh_enable, .o_selftest_enable(),
      .o_bus_shared_line, .o_battery_ctl);
   mmc_cmdr_model i_cmdr (.i_mclk, .o_req(i_csr_req), .i_rsp(o_csr_rsp));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step();
      @(posedge i_mclk);
      #1;
   endtask
   task automatic wr(input logic [19:0] off, input logic [31:0] d, input logic bc = 1'b0);
      i_cmdr.access(1'b1, bc, off, d, rd);
      step();
   endtask
   task automatic rd_chk(input logic [19:0] off, input logic [31:0] exp);
      i_cmdr.access(1'b0, 1'b0, off, 32'h0, rd);
      chk(rd, exp);
   endtask
   // Every configuration write carries the current rate so it is never disturbed
   task automatic cfg(input logic [31:0] d, input logic bc = 1'b0);
      wr(CFG, d | {26'h0, rate, 4'h0}, bc);
   endtask
   function automatic logic [31:0] exp_cfg(input logic disc, input logic shr);
      return {i_battery_ok, 2'h0, disc, 18'h0, i_option_dram, shr, 2'h0, rate, string_count, 2'h1};
   endfunction
   task automatic pulse_mem();
      i_mem_access = 1'b1;
      step();
      i_mem_access = 1'b0;
   endtask
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      rd_chk(MIC, 32'h0);
      rd_chk(CFG, exp_cfg(1'b0, 1'b0) | 32'h40);
      rd_chk(SEG, 32'h0);
      rd_chk(20'h01844, 32'h0);
      chk(32'(o_refresh_count), 32'h550);
      chk(32'(o_battery_ctl), 32'h1);
      // String strap moves; the synchronised copy follows after two edges
      string_count = 2'h3;
      repeat (3) step();
      rd_chk(CFG, exp_cfg(1'b0, 1'b0) | 32'h40);
      $display("reset test done");
   endtask
   task automatic t_interleave();
      for (int f = 0; f < 8; f++) begin
         wr(MIC, 32'h8000_0000 | 32'(f));
         chk(32'(o_interleave_factor), 32'(f));
         chk(32'(o_interleave_reserved), 32'(f > 4));
         chk(32'(o_mem_respond), 32'h1);
      end
      wr(MIC, 32'h7FFF_FFF3);
      rd_chk(MIC, 32'h3);
      chk(32'(o_mem_respond), 32'h0);
      wr(MIC, 32'h8000_0000, 1'b1);
      rd_chk(MIC, 32'h3);
      $display("interleave test done");
   endtask
   task automatic t_shared();
      wr(MIC, 32'h8000_0000);
      cfg(32'h0000_0100, 1'b1);
      rd_chk(CFG, exp_cfg(1'b0, 1'b1));
      pulse_mem();
      chk(32'(o_bus_shared_line), 32'h1);
      step();
      chk(32'(o_bus_shared_line), 32'h0);
      wr(MIC, 32'h0);
      pulse_mem();
      chk(32'(o_bus_shared_line), 32'h0);
      cfg(32'h0);
      $display("shared line test done");
   endtask
   task automatic t_rate();
      for (int c = 3; c >= 0; c--) begin
         rate = 2'(c);
         cfg(32'h0);
         chk(32'(o_refresh_count), 32'(EXP_CNT[c]));
      end
      $display("rate test done");
   endtask
   task automatic t_battery();
      cfg(32'h4000_0000);
      cfg(32'h0);
      cfg(32'h4000_0000);
      chk(32'(o_battery_ctl), 32'h1);
      cfg(32'h4000_0000);
      chk(32'(o_battery_ctl), 32'h0);
      i_battery_ok = 1'b0;
      repeat (3) step();
      rd_chk(CFG, exp_cfg(1'b1, 1'b0));
      cfg(32'h6000_0000);
      chk(32'(o_battery_ctl), 32'h1);
      rd_chk(CFG, exp_cfg(1'b0, 1'b0));
      i_battery_ok = 1'b1;
      $display("battery test done");
   endtask
   task automatic t_segments();
      seg = 32'h0;
      for (int k = 0; k < 2; k++) begin
         foreach (EXP_CNT[j]) begin
            i_mismatch = '{1'b1, (31'(j * 10 + 1) << 26) | 31'h3FF_FFFF};
            step();
         end
         i_mismatch.valid = 1'b0;
         rd_chk(SEG, seg);
         i_option_dram = 1'b1;
         repeat (4) step();
         chk(32'(o_refresh_enable), 32'h1);
         seg = 32'h8000_0802 | 32'h0020_0000;
      end
      wr(SEG, 32'h0000_0800);
      rd_chk(SEG, 32'h8020_0002);
      i_selftest_active = 1'b1;
      i_pause_on_error_continue = 1'b1;
      step();
      i_pause_on_error_continue = 1'b0;
      rd_chk(SEG, 32'h8020_0002);
      i_pause_on_error_mode = 1'b1;
      i_pause_on_error_continue = 1'b1;
      step();
      i_pause_on_error_continue = 1'b0;
      rd_chk(SEG, 32'h0);
      $display("segment test done");
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Hang guard well above the roughly 150 cycles the tests need
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         $display("[FAIL] %0t ns: run timed out", $time);
         print_verdict();
      end
   end
   initial begin
      {i_rst_n, i_mem_access, i_option_dram, i_selftest_active} = 4'h0;
      {i_pause_on_error_mode, i_pause_on_error_continue, rate} = 4'h0;
      i_battery_ok = 1'b1;
      string_count = 2'h2;
      i_mismatch = '0;
      repeat (12) @(posedge i_mclk);
      #1;
      i_rst_n = 1'b1;
      repeat (4) step();
      t_reset();
      t_interleave();
      t_shared();
      t_rate();
      t_battery();
      t_segments();
      print_verdict();
   end
endmodule // tb_top
